// >>> design/ctie_engine.sv
/*
 * cam table instruction engine: wishbone register slave, 64-bit cam
 * table in flip-flops, 12-deep entry queue and op code execution.
 * assumes: classic wishbone master on sys_clk, 32-bit data, registers
 * one per aligned word; synchronous active-low reset.
 */
// What this block does
// - insert, delete and check join io3 bit 15 to io0 bit 0 as one word.
// - buffered insert goes to first free queue slot and matches at once.
// - buffered insert with full queue stores nothing, error FFF8, error flag.
// - full-queue insert error interrupts only with enable bit 0.
// - fast insert writes table directly; table full gives FFF9 and error flag.
// - full-table insert error interrupts only with enable bit 1.
// - buffered insert with equal masked pattern replaces the existing entry.
// - delete compares unmasked bits only and invalidates the matching entry.
// - check hit sets matched flag and copies entry into io registers.
// - check miss clears the matched flag.
// - check completion interrupts whatever the result, with enable bit 2.
// - check completes within 8 clock cycles.
// - init completion sets initialized and buffered flags, interrupt bit 3.
// - during init all registers are read-only, counted from op acknowledge.
// - fast mode needs empty queue, else error FFFA and error flag.
// - failed fast-mode entry interrupts only with enable bit 4.
// - entering fast mode clears entry-mode and initialized flags.
// - after fast loading, matching is withheld until init completes.
// - buffered mode always accepted; its inserts and deletes use the queue.
// - table against queue conflicts resolve to the latest queued operation.
// - entry count returns valid table entries plus queued inserts in io0.
// - set mask loads io word; a 1 excludes a bit from matching.
// - each op register write while idle with byte lane 0 or 1 selected clears error flag and sets error code FFFF.
// - last-match result sits in flag bit 1.
`timescale 1ns/1ps
`include "ctie_defs.svh"

module ctie_engine #(
    parameter int DEPTH       = 4096,
    parameter int QDEPTH      = 12,
    parameter int INIT_CYCLES = `CTIE_INIT_TIME_US * `CTIE_CLK_MHZ
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // wishbone slave
    input  wire ctie_pkg::ctie_wb_req_t wb_req,
    output      ctie_pkg::ctie_wb_rsp_t wb_rsp,
    // interrupt request, held until the next op register write
    output      logic                  cam_irq
);
    import ctie_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int QW = $clog2(QDEPTH + 1);
    localparam int TW = $clog2(INIT_CYCLES + 1);
    localparam logic [CW-1:0] TBL_FULL  = CW'(DEPTH);
    localparam logic [QW-1:0] Q_FULL    = QW'(QDEPTH);
    localparam logic [TW-1:0] CHK_LAST  = TW'(`CTIE_CHECK_CYCLES - 1);
    localparam logic [TW-1:0] INIT_LAST = TW'(INIT_CYCLES - 1);

    // ==========================================================
    // state of the whole block
    typedef struct packed {
        ctie_wb_rsp_t                    rsp;
        logic                            irq;
        ctie_state_t                     st;
        logic [TW-1:0]                   tmr;
        logic [3:0][15:0]                io;
        logic [63:0]                     mask;
        logic [7:0]                      ien;
        logic [15:0]                     err;
        logic                            errf;
        logic                            matched;
        logic                            inited;
        logic                            bufmode;
        logic                            match_ok;
        logic                            done;
        logic [DEPTH-1:0]                tv;
        logic [DEPTH-1:0][63:0]          td;
        logic [CW-1:0]                   tcnt;
        ctie_q_entry_t [QDEPTH-1:0]      q;
        logic [QW-1:0]                   qcnt;
    } ctie_regs_t;

    ctie_regs_t s_q;
    ctie_regs_t s_d;

    // ==========================================================
    // word formed from the io registers
    logic [63:0] key;
    assign key = {s_q.io[3], s_q.io[2], s_q.io[1], s_q.io[0]};

    // ==========================================================
    // parallel masked compare of every table entry
    logic [DEPTH-1:0] key_hit;
    logic [DEPTH-1:0] head_hit;
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_cmp
            // a mask bit of 1 takes the position out of the compare
            assign key_hit[gi]  = s_q.tv[gi] &
                ~|((s_q.td[gi] ^ key) & ~s_q.mask);
            assign head_hit[gi] = s_q.tv[gi] &
                ~|((s_q.td[gi] ^ s_q.q[0].word) & ~s_q.mask);
        end
    endgenerate

    // ==========================================================
    // encoders: key hit, queue head hit, first free slot
    logic          key_any;
    logic          head_any;
    logic          free_any;
    logic [AW-1:0] key_idx;
    logic [AW-1:0] head_idx;
    logic [AW-1:0] free_idx;
    always_comb begin
        key_any  = 1'b0;
        head_any = 1'b0;
        free_any = 1'b0;
        key_idx  = '0;
        head_idx = '0;
        free_idx = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (key_hit[i]) begin
                key_any = 1'b1;
                key_idx = AW'(i);
            end
            if (head_hit[i]) begin
                head_any = 1'b1;
                head_idx = AW'(i);
            end
            if (!s_q.tv[i]) begin
                free_any = 1'b1;
                free_idx = AW'(i);
            end
        end
    end

    // ==========================================================
    // queue scan: latest entry matching the key, queued insert count
    logic          q_hit;
    ctie_q_entry_t q_last;
    logic [QW-1:0] q_ins;
    always_comb begin
        q_hit  = 1'b0;
        q_last = '0;
        q_ins  = '0;
        for (int i = 0; i < QDEPTH; i++) begin
            if (QW'(i) < s_q.qcnt) begin
                if (s_q.q[i].ins) begin
                    q_ins = q_ins + 1'b1;
                end
                if (~|((s_q.q[i].word ^ key) & ~s_q.mask)) begin
                    q_hit  = 1'b1; // later entries overwrite earlier
                    q_last = s_q.q[i];
                end
            end
        end
    end

    // ==========================================================
    // bus decode
    logic       take;
    logic       mapped;
    logic [2:0] idx;
    logic [15:0] wmerge;
    logic [15:0] rsel;
    logic [15:0] flags;
    assign take   = wb_req.cyc & wb_req.stb & ~s_q.rsp.ack;
    assign mapped = (wb_req.adr[7:5] == 3'h0);
    assign idx    = wb_req.adr[4:2];

    // flag register image, queue flags always from live counts
    always_comb begin
        flags                      = 16'h0000;
        flags[`CTIE_FLG_IRQ_ON]    = |s_q.ien;
        flags[`CTIE_FLG_MATCHED]   = s_q.matched;
        flags[`CTIE_FLG_INITED]    = s_q.inited;
        flags[`CTIE_FLG_BUFMODE]   = s_q.bufmode;
        flags[`CTIE_FLG_QEMPTY]    = (s_q.qcnt == '0);
        flags[`CTIE_FLG_QFULL]     = (s_q.qcnt == Q_FULL);
        flags[`CTIE_FLG_TFULL]     = (s_q.tcnt == TBL_FULL);
        flags[`CTIE_FLG_ERROR]     = s_q.errf;
        flags[`CTIE_FLG_DONE]      = s_q.done;
    end

    // read mux and byte-lane merge for 16-bit registers
    always_comb begin
        case (idx)
            `CTIE_IDX_IO0:  rsel = s_q.io[0];
            `CTIE_IDX_IO1:  rsel = s_q.io[1];
            `CTIE_IDX_IO2:  rsel = s_q.io[2];
            `CTIE_IDX_IO3:  rsel = s_q.io[3];
            `CTIE_IDX_FLAG: rsel = flags;
            `CTIE_IDX_ERR:  rsel = s_q.err;
            `CTIE_IDX_IEN:  rsel = {8'h00, s_q.ien};
            default:        rsel = 16'h0000;
        endcase
        wmerge[7:0]  = wb_req.sel[0] ? wb_req.dat[7:0]  : rsel[7:0];
        wmerge[15:8] = wb_req.sel[1] ? wb_req.dat[15:8] : rsel[15:8];
    end

    // ==========================================================
    // next state
    always_comb begin
        logic          wr_ok;
        logic          op_go;
        logic [15:0]   opc;
        logic          hit;
        logic [63:0]   hit_word;
        wr_ok    = 1'b0;
        op_go    = 1'b0;
        opc      = 16'h0000;
        hit      = 1'b0;
        hit_word = '0;
        s_d      = s_q;

        // bus answer, one registered ack per request, one cycle after it
        s_d.rsp.ack = take;
        if (take) begin
            s_d.rsp.dat = {16'h0000, mapped ? rsel : 16'h0000};
            wr_ok = wb_req.we & mapped & (s_q.st != CTIE_INIT);
        end
        if (wr_ok) begin
            case (idx)
                `CTIE_IDX_IO0: s_d.io[0] = wmerge;
                `CTIE_IDX_IO1: s_d.io[1] = wmerge;
                `CTIE_IDX_IO2: s_d.io[2] = wmerge;
                `CTIE_IDX_IO3: s_d.io[3] = wmerge;
                `CTIE_IDX_OP: begin
                    op_go = (s_q.st == CTIE_IDLE) & (|wb_req.sel[1:0]);
                    opc   = wmerge;
                end
                `CTIE_IDX_IEN: s_d.ien = wmerge[7:0];
                default: ;
            endcase
        end

        // background drain of the queue head into the table
        if (s_q.qcnt != '0 && s_q.st != CTIE_INIT) begin
            if (s_q.q[0].ins) begin
                if (head_any) begin
                    s_d.td[head_idx] = s_q.q[0].word;
                end else if (free_any) begin
                    s_d.td[free_idx] = s_q.q[0].word;
                    s_d.tv[free_idx] = 1'b1;
                    s_d.tcnt         = s_q.tcnt + 1'b1;
                end
            end else if (head_any) begin
                s_d.tv[head_idx] = 1'b0;
                s_d.tcnt         = s_q.tcnt - 1'b1;
            end
            for (int i = 0; i < QDEPTH - 1; i++) begin
                s_d.q[i] = s_q.q[i+1];
            end
            s_d.q[QDEPTH-1] = '0;
            s_d.qcnt        = s_q.qcnt - 1'b1;
        end

        // op code execution
        if (op_go) begin
            s_d.err  = `CTIE_ERR_NONE;
            s_d.errf = 1'b0;
            s_d.irq  = 1'b0;
            s_d.done = 1'b1;
            case (opc)
                `CTIE_OP_INSERT_A, `CTIE_OP_INSERT_B,
                `CTIE_OP_DELETE_A, `CTIE_OP_DELETE_B: begin
                    if (s_q.bufmode) begin
                        if (s_q.qcnt == Q_FULL) begin
                            s_d.err  = `CTIE_ERR_QFULL;
                            s_d.errf = 1'b1;
                            s_d.irq  = s_q.ien[`CTIE_IEN_QFULL];
                        end else begin
                            s_d.q[s_d.qcnt].ins  = (opc == `CTIE_OP_INSERT_A) |
                                                   (opc == `CTIE_OP_INSERT_B);
                            s_d.q[s_d.qcnt].word = key;
                            s_d.qcnt             = s_d.qcnt + 1'b1;
                        end
                    end else if ((opc == `CTIE_OP_DELETE_A) |
                                 (opc == `CTIE_OP_DELETE_B)) begin
                        if (key_any) begin
                            s_d.tv[key_idx] = 1'b0;
                            s_d.tcnt        = s_q.tcnt - 1'b1;
                        end
                    end else if (s_q.tcnt == TBL_FULL) begin
                        s_d.err  = `CTIE_ERR_TBLFULL;
                        s_d.errf = 1'b1;
                        s_d.irq  = s_q.ien[`CTIE_IEN_TFULL];
                    end else begin
                        s_d.td[free_idx] = key;
                        s_d.tv[free_idx] = 1'b1;
                        s_d.tcnt         = s_q.tcnt + 1'b1;
                        s_d.match_ok     = 1'b0;
                    end
                end
                `CTIE_OP_CHECK: begin
                    s_d.done = 1'b0;
                    s_d.st   = CTIE_CHECK;
                    s_d.tmr  = '0;
                end
                `CTIE_OP_INIT: begin
                    s_d.done = 1'b0;
                    s_d.st   = CTIE_INIT;
                    s_d.tmr  = '0;
                end
                `CTIE_OP_FAST: begin
                    if (s_q.qcnt == '0) begin
                        s_d.bufmode = 1'b0;
                        s_d.inited  = 1'b0;
                    end else begin
                        s_d.err  = `CTIE_ERR_QNOTEMPTY;
                        s_d.errf = 1'b1;
                        s_d.irq  = s_q.ien[`CTIE_IEN_FASTFAIL];
                    end
                end
                `CTIE_OP_BUFFERED: s_d.bufmode = 1'b1;
                `CTIE_OP_COUNT: begin
                    s_d.io[0] = 16'(s_q.tcnt) + 16'(q_ins);
                end
                `CTIE_OP_MASK_A, `CTIE_OP_MASK_B: begin
                    s_d.mask = key;
                end
                default: begin
                    s_d.err  = `CTIE_ERR_INVALID;
                    s_d.errf = 1'b1;
                    s_d.irq  = s_q.ien[`CTIE_IEN_ILLEGAL];
                end
            endcase
        end

        // multi-cycle operations
        case (s_q.st)
            CTIE_CHECK: begin
                s_d.tmr = s_q.tmr + 1'b1;
                if (s_q.tmr == CHK_LAST) begin
                    if (q_hit) begin
                        hit      = q_last.ins;
                        hit_word = q_last.word;
                    end else begin
                        hit      = key_any;
                        hit_word = s_q.td[key_idx];
                    end
                    hit           = hit & s_q.match_ok;
                    s_d.matched   = hit;
                    if (hit) begin
                        s_d.io = hit_word;
                    end
                    s_d.irq  = s_q.ien[`CTIE_IEN_CHECK];
                    s_d.done = 1'b1;
                    s_d.st   = CTIE_IDLE;
                end
            end
            CTIE_INIT: begin
                s_d.tmr = s_q.tmr + 1'b1;
                if (s_q.tmr == INIT_LAST) begin
                    s_d.inited   = 1'b1;
                    s_d.bufmode  = 1'b1;
                    s_d.match_ok = 1'b1;
                    s_d.irq      = s_q.ien[`CTIE_IEN_INIT];
                    s_d.done     = 1'b1;
                    s_d.st       = CTIE_IDLE;
                end
            end
            default: ;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q          <= '0;
            s_q.st       <= CTIE_IDLE;
            s_q.err      <= `CTIE_ERR_NONE;
            s_q.bufmode  <= 1'b1;
            s_q.match_ok <= 1'b1;
            s_q.done     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign wb_rsp  = s_q.rsp;
    assign cam_irq = s_q.irq;

endmodule

// >>> design/ctie_defs.svh
/*
 * constants of the cam instruction engine: register indexes, op codes,
 * error codes, flag and interrupt-enable bit positions, timing figures.
 * assumes: included by bare name from the engine and the test bench.
 */
`ifndef CTIE_DEFS_SVH
`define CTIE_DEFS_SVH

// ==========================================================
// register indexes (byte address = 4 x index)
`define CTIE_IDX_IO0        3'h0
`define CTIE_IDX_IO1        3'h1
`define CTIE_IDX_IO2        3'h2
`define CTIE_IDX_IO3        3'h3
`define CTIE_IDX_OP         3'h4
`define CTIE_IDX_FLAG       3'h5
`define CTIE_IDX_ERR        3'h6
`define CTIE_IDX_IEN        3'h7

// ==========================================================
// op codes
`define CTIE_OP_INSERT_A    16'h0000
`define CTIE_OP_INSERT_B    16'h000F
`define CTIE_OP_DELETE_A    16'h0001
`define CTIE_OP_DELETE_B    16'h000E
`define CTIE_OP_CHECK       16'h0006
`define CTIE_OP_INIT        16'h000B
`define CTIE_OP_FAST        16'h0004
`define CTIE_OP_BUFFERED    16'h0005
`define CTIE_OP_COUNT       16'h0003
`define CTIE_OP_MASK_A      16'h0002
`define CTIE_OP_MASK_B      16'h000D

// ==========================================================
// error codes
`define CTIE_ERR_NONE       16'hFFFF
`define CTIE_ERR_INVALID    16'hFFFD
`define CTIE_ERR_QNOTEMPTY  16'hFFFA
`define CTIE_ERR_TBLFULL    16'hFFF9
`define CTIE_ERR_QFULL      16'hFFF8

// ==========================================================
// flag bits
`define CTIE_FLG_IRQ_ON     0
`define CTIE_FLG_MATCHED    1
`define CTIE_FLG_INITED     2
`define CTIE_FLG_BUFMODE    3
`define CTIE_FLG_QEMPTY     4
`define CTIE_FLG_QFULL      5
`define CTIE_FLG_TFULL      6
`define CTIE_FLG_ERROR      7
`define CTIE_FLG_DONE       10

// ==========================================================
// interrupt-enable bits
`define CTIE_IEN_QFULL      0
`define CTIE_IEN_TFULL      1
`define CTIE_IEN_CHECK      2
`define CTIE_IEN_INIT       3
`define CTIE_IEN_FASTFAIL   4
`define CTIE_IEN_ILLEGAL    7

// ==========================================================
// timing
`define CTIE_CLK_MHZ        250
`define CTIE_INIT_TIME_US   12000
`define CTIE_CHECK_CYCLES   8

`endif

// >>> design/ctie_pkg.sv
/*
 * types of the cam instruction engine: wishbone carriers, queue entry,
 * engine states.
 * assumes: ctie_defs.svh on the include path.
 */
package ctie_pkg;

    // ==========================================================
    // wishbone carriers
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ctie_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ctie_wb_rsp_t;

    // ==========================================================
    // entry queue element: insert (1) or delete (0) plus word
    typedef struct packed {
        logic        ins;
        logic [63:0] word;
    } ctie_q_entry_t;

    typedef enum logic [1:0] {
        CTIE_IDLE,
        CTIE_CHECK,
        CTIE_INIT
    } ctie_state_t;

endpackage

// >>> testbench/ctie_engine_monitor.sv
/*
 * bus and register read checks of the cam instruction engine.
 * assumes: bound to ctie_engine, one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps

module ctie_engine_monitor (
    // clock and reset
    input wire logic             sys_clk,
    input wire logic             rst_n,
    // watched ports
    input ctie_pkg::ctie_wb_req_t wb_req,
    input ctie_pkg::ctie_wb_rsp_t wb_rsp,
    input wire logic             cam_irq
);
    import ctie_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // bus steps
    sequence s_take;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    sequence s_rd(logic [7:0] a);
        wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_req.we && wb_req.adr == a;
    endsequence

    property p_ack_after_take; s_take |=> wb_rsp.ack; endproperty
    a_ack_after_take: assert property (p_ack_after_take) else $error("ack missing");
    property p_ack_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; $rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_err_form; s_rd(8'h18) |=> wb_rsp.dat[31:3] == {16'h0000, 13'h1FFF}; endproperty
    a_err_form: assert property (p_err_form) else $error("bad error code");
    property p_op_zero; s_rd(8'h10) |=> wb_rsp.dat == 32'h0000_0000; endproperty
    a_op_zero: assert property (p_op_zero) else $error("op reg not zero");
    property p_unmapped; s_rd(8'h20) |=> wb_rsp.dat == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    property p_flag_rsvd; s_rd(8'h14) |=> wb_rsp.dat[31:11] == 0 && wb_rsp.dat[9:8] == 0;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved flags set");
    property p_queue_flags; s_rd(8'h14) |=> !(wb_rsp.dat[4] && wb_rsp.dat[5]); endproperty
    a_queue_flags: assert property (p_queue_flags) else $error("empty and full");
    property p_dat_stands; !wb_rsp.ack ##1 !wb_rsp.ack |-> $stable(wb_rsp.dat); endproperty
    a_dat_stands: assert property (p_dat_stands) else $error("read data moved");
    property p_irq_hold;
        $fell(cam_irq) |-> $past(wb_req.cyc && wb_req.stb && wb_req.we && wb_req.adr == 8'h10);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
endmodule

// >>> testbench/ctie_host_model.sv
/*
 * host model: classic wishbone single cycles to the engine registers.
 * assumes: tasks called right after a rising edge of sys_clk.
 */
`timescale 1ns/1ps

module ctie_host_model (
    // clock
    input wire logic             sys_clk,
    // bus
    output ctie_pkg::ctie_wb_req_t req,
    input ctie_pkg::ctie_wb_rsp_t  rsp
);
    import ctie_pkg::*;
    initial req = '0;

    // one cycle, held until ack, one idle cycle after
    task automatic cyc(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        req <= '{1'b1, 1'b1, w, a, 4'hF, {16'h0000, d}};
        do @(posedge sys_clk); while (rsp.ack !== 1'b1);
        q = rsp.dat[15:0];
        req <= '0;
        @(posedge sys_clk);
    endtask
endmodule

// >>> testbench/cam_table_instruction_engine_test.sv
/*
 * self-checking bench of the cam instruction engine.
 * assumes: small table (16) and short init (20 cycles) for simulation.
 */
`timescale 1ns/1ps
`include "ctie_defs.svh"

module cam_table_instruction_engine_test;
    import ctie_pkg::*;
    typedef struct packed {
        logic [63:0] w;
        logic [15:0] op, err, io0;
        logic        m, irq;
    } ctie_row_t;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         cam_irq;
    ctie_wb_req_t wb_req;
    ctie_wb_rsp_t wb_rsp;
    logic [15:0]  v, q;
    int           fail_count = 0;
    int           num_checks = 0;
    ctie_row_t    rows [10] = '{
        '{64'h0000_0000_FFFF_FFFF, `CTIE_OP_MASK_A, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0},
        '{64'h1234_5678_0000_00AA, `CTIE_OP_INSERT_A, 16'hFFFF, 16'h00AA, 1'b0, 1'b0},
        '{64'h1234_5678_0000_00AA, `CTIE_OP_CHECK, 16'hFFFF, 16'h00AA, 1'b1, 1'b1},
        '{64'h1234_5679_0000_00BB, `CTIE_OP_CHECK, 16'hFFFF, 16'h00BB, 1'b0, 1'b1},
        '{64'h1234_5678_0000_00CC, `CTIE_OP_INSERT_B, 16'hFFFF, 16'h00CC, 1'b0, 1'b0},
        '{64'h0, `CTIE_OP_COUNT, 16'hFFFF, 16'h0001, 1'b0, 1'b0},
        '{64'h1234_5678_0000_0000, `CTIE_OP_CHECK, 16'hFFFF, 16'h00CC, 1'b1, 1'b1},
        '{64'h1234_5678_FFFF_0011, `CTIE_OP_DELETE_B, 16'hFFFF, 16'h0011, 1'b1, 1'b0},
        '{64'h0, `CTIE_OP_COUNT, 16'hFFFF, 16'h0000, 1'b1, 1'b0},
        '{64'h0, 16'h0008, `CTIE_ERR_INVALID, 16'h0000, 1'b1, 1'b0}};

    always #2 sys_clk = ~sys_clk;

    ctie_engine #(.DEPTH(16), .QDEPTH(12), .INIT_CYCLES(20)) ctie_engine_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .cam_irq(cam_irq));
    ctie_host_model ctie_host_model_inst (.sys_clk(sys_clk), .req(wb_req), .rsp(wb_rsp));

    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        ctie_host_model_inst.cyc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        ctie_host_model_inst.cyc(1'b0, a, 16'h0000, q);
    endtask
    task automatic put(input logic [63:0] w);
        for (int k = 0; k < 4; k++) wr(8'(k * 4), w[k*16+:16]);
    endtask
    task automatic done_wait;
        v = 16'h0000;
        for (int n = 0; n < 60 && v[10] !== 1'b1; n++) begin
            rd(8'h14);
            v = q;
        end
        chk(v & 16'h0400, 16'h0400);
    endtask
    task automatic op(input logic [15:0] c);
        wr(8'h10, c);
        done_wait();
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        wr(8'h1C, 16'h000E);
        foreach (rows[i]) begin
            put(rows[i].w);
            op(rows[i].op);
            rd(8'h18); chk(q, rows[i].err);
            rd(8'h00); chk(q, rows[i].io0);
            chk({15'h0, v[1]}, {15'h0, rows[i].m});
            chk({15'h0, cam_irq}, {15'h0, rows[i].irq});
        end
        // mid-run reset: error, match flag and table back to reset state
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(8'h14); chk(q, 16'h0418);
        rd(8'h18); chk(q, `CTIE_ERR_NONE);
        rd(8'h20); chk(q, 16'h0000);
        wr(8'h1C, 16'h000E);
        op(`CTIE_OP_FAST);
        chk(v & 16'h000C, 16'h0000);
        for (int i = 1; i <= 17; i++) begin
            put({8'h00, 8'(i), 48'h0});
            op(`CTIE_OP_INSERT_A);
        end
        rd(8'h18); chk(q, `CTIE_ERR_TBLFULL);
        chk(v & 16'h00C0, 16'h00C0);
        chk({15'h0, cam_irq}, 16'h0001);
        put({8'h00, 8'h01, 48'h0});
        op(`CTIE_OP_CHECK);
        chk({15'h0, v[1]}, 16'h0000);
        wr(8'h10, `CTIE_OP_INIT);
        wr(8'h00, 16'h1234);
        done_wait();
        chk(v & 16'h000C, 16'h000C);
        chk({15'h0, cam_irq}, 16'h0001);
        rd(8'h00); chk(q, 16'h0000);
        op(`CTIE_OP_CHECK);
        chk({15'h0, v[1]}, 16'h0001);
        report_and_stop();
    end
endmodule

bind ctie_engine ctie_engine_monitor ctie_engine_monitor_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .cam_irq(cam_irq));
